// ---- hdl/hti_cmd_port.sv ----
`timescale 1ns/1ns
// How it works
// R1: answer only address 0x70; writes carry commands
// R2: ack by pulling sda low after eighth fall
// R3: two command bytes, each acked separately
// R4: measurement starts at command acknowledge
// R5: 0x7ca2, 0x5c24 stretch; temperature or humidity first
// R6: 0x7866, 0x58e0 no stretch; order likewise
// R7: headers unacked while measuring, unless stretching
// R8: stretching: ack read, hold scl, then send
// R9: after measurement: word, crc, word, crc
// R10: missing master ack stops transmission
// R11: readout order follows starting command
// R12: master may nack any byte early
// R13: master should nack after second word's data
// R14: 0x805d in idle resets everything, reloads
// R15: 0xefc8 then read gives id word, crc
// R16: id bits 5:0 fixed code, rest free
// R17: idle after power-up and between activities
// R18: transfers open with start; stop optional
// R19: master keeps scl at or below 400 khz
// R20: master only pulls lines low
// R21: master should stay quiet during measurement
// R22: check byte crc-8, poly 0x31, init 0xff
// R23: words msb byte first, bits msb first
// R24: results kept until new command or reset
module hti_cmd_port #(
    parameter int               MEAS_CYCLES = hti_pkg::MEAS_CYC,
    parameter logic [9:0]       ID_FREE     = hti_pkg::ID_FREE_RESET,
    parameter logic [5:0]       ID_CODE     = hti_pkg::ID_CODE_RESET
) (
    input  wire logic           clk_sys_in,
    input  wire logic           rst_n_in,
    input  wire logic           scl_in,
    input  wire logic           sda_in,
    input  wire logic [15:0]    humidity_in,
    input  wire logic [15:0]    temperature_in,
    output logic                scl_out,
    output logic                scl_oe_out,
    output logic                sda_out,
    output logic                sda_oe_out,
    output logic                meas_start_out,
    output logic                measuring_out,
    output logic                idle_out
);
    import hti_pkg::*;

    hti_state_t  state_reg;
    logic        scl_s1, scl_s2, scl_s3;
    logic        sda_s1, sda_s2, sda_s3;
    logic [7:0]  rx_sh_reg, tx_sh_reg;
    logic [3:0]  bit_cnt_reg;
    logic [1:0]  cmd_cnt_reg, tx_pos_reg;
    logic [15:0] cmd_reg;
    logic        tx_wsel_reg, more_reg, stretch_mode_reg, temp_first_reg, id_sel_reg, setup_reg;
    logic        soft_rst_reg, cmd_ok_reg, meas_reg, valid_reg, low_reg;
    logic [31:0] meas_cnt_reg;
    logic [11:0] boot_cnt_reg;
    logic [15:0] hum_reg, temp_reg;
    logic        scl_rise, scl_fall, start_cond, stop_cond, booting;
    logic [15:0] first_word, cur_word;
    logic [7:0]  cur_crc, cur_byte;
    logic        last_byte;
    logic        addr_hit;

    // two flops per pin before use; the third only feeds edge detection
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            {scl_s3, scl_s2, scl_s1} <= 3'h7;
            {sda_s3, sda_s2, sda_s1} <= 3'h7;
        end else begin
            {scl_s3, scl_s2, scl_s1} <= {scl_s2, scl_s1, scl_in};
            {sda_s3, sda_s2, sda_s1} <= {sda_s2, sda_s1, sda_in};
        end
    end

    // bus events
    assign scl_rise   = scl_s2 & ~scl_s3;
    assign scl_fall   = ~scl_s2 & scl_s3;
    assign start_cond = scl_s2 & scl_s3 & sda_s3 & ~sda_s2; // R18
    assign stop_cond  = scl_s2 & scl_s3 & ~sda_s3 & sda_s2;
    assign booting    = (boot_cnt_reg != 12'h000);
    assign addr_hit   = (rx_sh_reg[7:1] == I2C_ADDR) && !booting; // R1

    // byte source: word order, then hi, lo, crc of each word
    assign first_word = id_sel_reg ? {ID_FREE, ID_CODE} :           // R16
                        (temp_first_reg ? temp_reg : hum_reg);       // R11
    assign cur_word   = tx_wsel_reg ? (temp_first_reg ? hum_reg : temp_reg) : first_word;
    assign cur_byte   = (tx_pos_reg == 2'd0) ? cur_word[15:8] :     // R23
                        (tx_pos_reg == 2'd1) ? cur_word[7:0] : cur_crc;
    // id readout ends after one word, measurements after two
    assign last_byte  = (tx_pos_reg == 2'd2) && (id_sel_reg || tx_wsel_reg); // R15 R9

    hti_crc8 u_crc (
        .word_in (cur_word),
        .crc_out (cur_crc)
    );

    // protocol engine; soft reset drops every transfer in progress
    always_ff @(posedge clk_sys_in) begin
        soft_rst_reg   <= 1'b0;
        cmd_ok_reg     <= 1'b0;
        meas_start_out <= 1'b0;
        if (!rst_n_in || soft_rst_reg) begin // R14
            state_reg        <= ST_IDLE;
            {rx_sh_reg, tx_sh_reg} <= 16'h0000;
            bit_cnt_reg      <= 4'h0;
            {cmd_cnt_reg, tx_pos_reg} <= 4'h0;
            cmd_reg          <= 16'h0000;
            {tx_wsel_reg, more_reg, stretch_mode_reg, temp_first_reg, id_sel_reg, setup_reg} <= 6'h00;
            {scl_oe_out, sda_oe_out} <= 2'h0;
        end else if (start_cond) begin
            state_reg   <= ST_ADDR;
            bit_cnt_reg <= 4'h0;
            {scl_oe_out, sda_oe_out} <= 2'h0;
        end else if (stop_cond) begin
            state_reg  <= ST_IDLE; // R17
            {scl_oe_out, sda_oe_out} <= 2'h0;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    sda_oe_out <= 1'b0;
                end
                ST_ADDR, ST_CMD: begin
                    if (scl_rise) begin
                        rx_sh_reg   <= {rx_sh_reg[6:0], sda_s2};
                        bit_cnt_reg <= bit_cnt_reg + 4'h1;
                    end else if (scl_fall && bit_cnt_reg == 4'h8) begin
                        state_reg  <= ST_IDLE;
                        tx_pos_reg <= 2'h0;
                        tx_wsel_reg <= 1'b0;
                        if (state_reg == ST_CMD) begin
                            cmd_reg     <= {cmd_reg[7:0], rx_sh_reg};
                            cmd_cnt_reg <= cmd_cnt_reg + 2'h1;
                            sda_oe_out  <= 1'b1; // R3 R2
                            state_reg   <= ST_ACK_WR;
                        end else if (addr_hit && !rx_sh_reg[0] && !meas_reg) begin // R7
                            cmd_cnt_reg <= 2'h0;
                            sda_oe_out  <= 1'b1; // R2
                            state_reg   <= ST_ACK_WR;
                        end else if (addr_hit && rx_sh_reg[0] &&
                                     ((meas_reg && stretch_mode_reg) ||            // R8 R7
                                      (!meas_reg && (valid_reg || id_sel_reg)))) begin // R9 R24
                            sda_oe_out <= 1'b1;
                            state_reg  <= ST_ACK_RD;
                        end
                    end
                end
                ST_ACK_WR: begin
                    if (scl_fall) begin
                        sda_oe_out  <= 1'b0;
                        bit_cnt_reg <= 4'h0;
                        state_reg   <= ST_CMD;
                        if (cmd_cnt_reg == 2'h2) begin
                            // command acts once its second byte is acknowledged
                            state_reg <= ST_IDLE;
                            case (cmd_reg)
                                CMD_MEAS_CS_TFIRST, CMD_MEAS_CS_HFIRST,
                                CMD_MEAS_NS_TFIRST, CMD_MEAS_NS_HFIRST: begin
                                    meas_start_out   <= 1'b1; // R4
                                    cmd_ok_reg       <= 1'b1;
                                    id_sel_reg       <= 1'b0;
                                    stretch_mode_reg <= (cmd_reg == CMD_MEAS_CS_TFIRST) ||
                                                        (cmd_reg == CMD_MEAS_CS_HFIRST); // R5 R6
                                    temp_first_reg   <= (cmd_reg == CMD_MEAS_CS_TFIRST) ||
                                                        (cmd_reg == CMD_MEAS_NS_TFIRST); // R5 R6
                                end
                                CMD_READ_ID: begin
                                    id_sel_reg <= 1'b1; // R15
                                    cmd_ok_reg <= 1'b1;
                                end
                                CMD_SOFT_RESET: begin
                                    soft_rst_reg <= 1'b1; // R14
                                end
                                default: begin
                                end
                            endcase
                        end
                    end
                end
                ST_ACK_RD: begin
                    if (scl_fall) begin
                        bit_cnt_reg <= 4'h0;
                        if (meas_reg) begin
                            sda_oe_out <= 1'b0;
                            scl_oe_out <= 1'b1; // R8
                            state_reg  <= ST_STRETCH;
                        end else begin
                            tx_sh_reg  <= cur_byte;
                            sda_oe_out <= ~cur_byte[7];
                            state_reg  <= ST_TX;
                        end
                    end
                end
                ST_STRETCH: begin
                    // present the first bit, then free scl one cycle later for setup
                    if (setup_reg) begin
                        setup_reg  <= 1'b0;
                        scl_oe_out <= 1'b0;
                        state_reg  <= ST_TX;
                    end else if (!meas_reg && valid_reg) begin
                        tx_sh_reg  <= cur_byte; // R8
                        sda_oe_out <= ~cur_byte[7];
                        setup_reg  <= 1'b1;
                    end
                end
                ST_TX: begin
                    if (scl_rise) begin
                        bit_cnt_reg <= bit_cnt_reg + 4'h1;
                    end else if (scl_fall) begin
                        if (bit_cnt_reg == 4'h8) begin
                            sda_oe_out <= 1'b0;
                            state_reg  <= ST_MACK;
                        end else begin
                            tx_sh_reg  <= {tx_sh_reg[6:0], 1'b0}; // R23
                            sda_oe_out <= ~tx_sh_reg[6];
                        end
                    end
                end
                ST_MACK: begin
                    if (scl_rise) begin
                        more_reg <= ~sda_s2 && !last_byte; // R10 R12
                        if (tx_pos_reg == 2'd2) begin
                            tx_pos_reg  <= 2'd0;
                            tx_wsel_reg <= 1'b1;
                        end else begin
                            tx_pos_reg <= tx_pos_reg + 2'd1;
                        end
                    end else if (scl_fall) begin
                        bit_cnt_reg <= 4'h0;
                        if (more_reg) begin
                            tx_sh_reg  <= cur_byte;
                            sda_oe_out <= ~cur_byte[7];
                            state_reg  <= ST_TX;
                        end else begin
                            state_reg <= ST_IDLE; // R10
                        end
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // measurement timer; results latch at its end and stay until a new command
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in || soft_rst_reg) begin
            meas_reg     <= 1'b0;
            valid_reg    <= 1'b0;
            meas_cnt_reg <= 32'h0000_0000;
            {hum_reg, temp_reg} <= 32'h0000_0000;
        end else if (meas_start_out) begin
            meas_reg     <= 1'b1; // R4
            valid_reg    <= 1'b0;
            meas_cnt_reg <= 32'(MEAS_CYCLES);
        end else if (cmd_ok_reg) begin
            valid_reg <= 1'b0; // R24
        end else if (meas_reg && meas_cnt_reg <= 32'h0000_0001) begin
            meas_reg  <= 1'b0;
            valid_reg <= 1'b1; // R24
            {hum_reg, temp_reg} <= {humidity_in, temperature_in};
        end else if (meas_reg) begin
            meas_cnt_reg <= meas_cnt_reg - 32'h0000_0001;
        end
    end

    // power-up and soft-reset reload window: no header is acknowledged
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            boot_cnt_reg <= 12'(PU_CYC);
        end else if (soft_rst_reg) begin
            boot_cnt_reg <= 12'(SR_CYC); // R14
        end else if (booting) begin
            boot_cnt_reg <= boot_cnt_reg - 12'h001;
        end
    end

    // status outputs; line levels are open drain, so driven value is always low
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            measuring_out <= 1'b0;
            idle_out      <= 1'b0;
            low_reg       <= 1'b0;
        end else begin
            measuring_out <= meas_reg;
            idle_out      <= (state_reg == ST_IDLE) && !meas_reg && !booting; // R17
            low_reg       <= 1'b0;
        end
    end

    assign scl_out = low_reg;
    assign sda_out = low_reg;
endmodule

// ---- common/hti_pkg.sv ----
// shared constants for the humidity/temperature command port
package hti_pkg;

    // system clock
    localparam int CLK_PERIOD_NS = 100;

    // bus address and command codes
    localparam logic [6:0]  I2C_ADDR          = 7'h70;
    localparam logic [15:0] CMD_MEAS_CS_TFIRST = 16'h7ca2;
    localparam logic [15:0] CMD_MEAS_CS_HFIRST = 16'h5c24;
    localparam logic [15:0] CMD_MEAS_NS_TFIRST = 16'h7866;
    localparam logic [15:0] CMD_MEAS_NS_HFIRST = 16'h58e0;
    localparam logic [15:0] CMD_SOFT_RESET     = 16'h805d;
    localparam logic [15:0] CMD_READ_ID        = 16'hefc8;

    // check byte
    localparam logic [7:0] CRC_POLY = 8'h31;
    localparam logic [7:0] CRC_INIT = 8'hff;

    // identification word layout: [15:6] free content, [5:0] product code
    localparam int ID_CODE_LSB = 0;
    localparam int ID_CODE_W   = 6;
    localparam int ID_FREE_LSB = 6;
    localparam int ID_FREE_W   = 10;
    // arbitrary values, not those of any real part
    localparam logic [5:0] ID_CODE_RESET = 6'h07;
    localparam logic [9:0] ID_FREE_RESET = 10'h000;

    // worst-case timings, rounded down to whole cycles
    localparam int T_PU_NS   = 239000;
    localparam int T_SR_NS   = 230000;
    localparam int T_MEAS_NS = 14400000;
    localparam int PU_CYC    = (T_PU_NS / CLK_PERIOD_NS) < 1 ? 1 : T_PU_NS / CLK_PERIOD_NS;
    localparam int SR_CYC    = (T_SR_NS / CLK_PERIOD_NS) < 1 ? 1 : T_SR_NS / CLK_PERIOD_NS;
    localparam int MEAS_CYC  = (T_MEAS_NS / CLK_PERIOD_NS) < 1 ? 1 : T_MEAS_NS / CLK_PERIOD_NS;

    // protocol states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_CMD,
        ST_ACK_WR,
        ST_ACK_RD,
        ST_STRETCH,
        ST_TX,
        ST_MACK
    } hti_state_t;

endpackage

// ---- hdl/hti_crc8.sv ----
`timescale 1ns/1ns
// crc-8 over a 16-bit word, msb first, no reflection, no final xor
module hti_crc8 (
    input  wire logic [15:0] word_in,
    output logic      [7:0]  crc_out
);
    import hti_pkg::*;

    function automatic logic [7:0] crc_of(input logic [15:0] w);
        logic [7:0] c;
        c = CRC_INIT;
        for (int i = 15; i >= 0; i--) begin
            if (c[7] ^ w[i]) begin
                c = {c[6:0], 1'b0} ^ CRC_POLY;
            end else begin
                c = {c[6:0], 1'b0};
            end
        end
        return c;
    endfunction

    assign crc_out = crc_of(word_in); // R22
endmodule

// ---- dv/hti_cmd_port_asserts.sv ----
`timescale 1ns/1ns
// port watcher; one clock domain, so clock and disable are declared once
module hti_cmd_port_asserts #(
    parameter int MEAS_CYCLES = 50
) (
    input wire logic        clk_sys_in,
    input wire logic        rst_n_in,
    input wire logic        scl_in,
    input wire logic        sda_in,
    input wire logic [15:0] humidity_in,
    input wire logic [15:0] temperature_in,
    input wire logic        scl_out,
    input wire logic        scl_oe_out,
    input wire logic        sda_out,
    input wire logic        sda_oe_out,
    input wire logic        meas_start_out,
    input wire logic        measuring_out,
    input wire logic        idle_out
);
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!rst_n_in);
    int meas_len;

    // run length of measuring_out; counted, as the run is far too long to unroll
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in || !measuring_out) begin
            meas_len <= 0;
        end else begin
            meas_len <= meas_len + 1;
        end
    end

    a_pins_pull_low: assert property (!scl_out && !sda_out)
        else $error("line driven high");
    a_start_one_cycle: assert property (meas_start_out |=> !meas_start_out ##1 measuring_out)
        else $error("start pulse not followed by measurement");
    a_meas_has_start: assert property ($rose(measuring_out) |-> $past(meas_start_out, 2))
        else $error("measurement without start pulse");
    a_start_low_clock: assert property (meas_start_out |-> !scl_in)
        else $error("measurement started outside acknowledge");
    a_meas_full_len: assert property ($fell(measuring_out) |-> meas_len == MEAS_CYCLES)
        else $error("measurement length wrong");
    a_idle_is_quiet: assert property (idle_out |-> !measuring_out && !scl_oe_out)
        else $error("idle while busy");
    a_stretch_cause: assert property ($rose(scl_oe_out) |-> measuring_out)
        else $error("clock held without measurement");
    a_stretch_holds: assert property (scl_oe_out && measuring_out |=> scl_oe_out || !measuring_out)
        else $error("clock released before measurement end");
    a_stretch_release: assert property ($fell(measuring_out) && scl_oe_out |-> ##[0:6] !scl_oe_out)
        else $error("clock still held after measurement");
    a_sda_on_low_clk: assert property ($changed(sda_oe_out) |-> !scl_in)
        else $error("data changed while clock high");

    c_meas_start: cover property (meas_start_out);
    c_stretch: cover property ($rose(scl_oe_out));
    c_meas_done: cover property ($fell(measuring_out));
endmodule

bind hti_cmd_port hti_cmd_port_asserts #(.MEAS_CYCLES(MEAS_CYCLES)) u_chk (
    .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .scl_in(scl_in), .sda_in(sda_in),
    .humidity_in(humidity_in), .temperature_in(temperature_in), .scl_out(scl_out),
    .scl_oe_out(scl_oe_out), .sda_out(sda_out), .sda_oe_out(sda_oe_out),
    .meas_start_out(meas_start_out), .measuring_out(measuring_out), .idle_out(idle_out)
);

// ---- dv/hti_i2c_master.sv ----
`timescale 1ns/1ns
// bus master model; lines are only pulled low or released to the pull-ups
module hti_i2c_master #(
    parameter int HALF = 20
) (
    input  wire logic clk_sys_in,
    input  wire logic scl_in,
    input  wire logic sda_in,
    output logic      scl_m_out,
    output logic      sda_m_out
);
    // both lines released at time zero
    initial begin
        scl_m_out = 1'b1;
        sda_m_out = 1'b1;
    end

    // wait n cycles, then step just past the edge
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys_in);
        #5;
    endtask

    // release scl and follow the device while it stretches, bounded
    task automatic scl_up();
        scl_m_out = 1'b1;
        for (int k = 0; k < 20000 && scl_in !== 1'b1; k++) tick(1);
    endtask

    // one bit: drive v in the low phase, sample the wire mid-high
    task automatic bit_xfer(input logic v, output logic s);
        tick(4);
        sda_m_out = v;
        tick(HALF);
        scl_up();
        tick(HALF / 2);
        s = sda_in;
        tick(HALF / 2);
        scl_m_out = 1'b0;
    endtask

    task automatic start();
        tick(4);
        sda_m_out = 1'b1;
        tick(HALF);
        scl_up();
        tick(HALF);
        sda_m_out = 1'b0;
        tick(HALF);
        scl_m_out = 1'b0;
    endtask

    // stop is optional for the master but keeps the bus tidy
    task automatic stop();
        tick(4);
        sda_m_out = 1'b0;
        tick(HALF);
        scl_up();
        tick(HALF);
        sda_m_out = 1'b1;
        tick(HALF);
    endtask

    task automatic wbyte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_xfer(b[i], s);
        bit_xfer(1'b1, s);
        ack = ~s;
    endtask

    // nack high ends the read after this byte
    task automatic rbyte(input logic nack, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) bit_xfer(1'b1, b[i]);
        bit_xfer(nack, s);
    endtask
endmodule

// ---- dv/humidity_temp_i2c_command_port_test.sv ----
`timescale 1ns/1ns
module humidity_temp_i2c_command_port_test;
    import hti_pkg::*;
    localparam int         MEAS_N = 2000;
    localparam logic [9:0] FREE   = 10'h2b5;
    localparam logic [15:0] CMDS [4] = '{CMD_MEAS_CS_TFIRST, CMD_MEAS_CS_HFIRST,
                                         CMD_MEAS_NS_TFIRST, CMD_MEAS_NS_HFIRST};
    logic        clk_sys_in = 1'b0;
    logic        rst_n_in   = 1'b0;
    logic [15:0] hum        = 16'hbeef;
    logic [15:0] tmp        = 16'h0000;
    logic [15:0] e0, e1;
    logic [7:0]  b [6];
    logic        ack;
    int          fail_count = 0;
    int          n_checks   = 0;
    wire         scl_m, sda_m, scl_oe, sda_oe, meas, idle;
    wire         scl = scl_m & ~scl_oe;
    wire         sda = sda_m & ~sda_oe;

    always #50 clk_sys_in = ~clk_sys_in;

    hti_cmd_port #(.MEAS_CYCLES(MEAS_N), .ID_FREE(FREE), .ID_CODE(ID_CODE_RESET)) DUT (
        .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .scl_in(scl), .sda_in(sda),
        .humidity_in(hum), .temperature_in(tmp), .scl_out(), .scl_oe_out(scl_oe),
        .sda_out(), .sda_oe_out(sda_oe), .meas_start_out(), .measuring_out(meas), .idle_out(idle)
    );
    hti_i2c_master M (.clk_sys_in(clk_sys_in), .scl_in(scl), .sda_in(sda), .scl_m_out(scl_m), .sda_m_out(sda_m));

    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask

    // reference check byte, worked bit by bit
    function automatic logic [7:0] crc8(input logic [15:0] w);
        logic [7:0] c;
        c = 8'hff;
        for (int i = 15; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ w[i]) ? 8'h31 : 8'h00);
        return c;
    endfunction

    task automatic hdr(input logic [7:0] h, input logic exp);
        M.start();
        M.wbyte(h, ack);
        chk("header ack", ack, exp);
    endtask

    task automatic send_cmd(input logic [15:0] c);
        hdr(8'he0, 1'b1);
        M.wbyte(c[15:8], ack);
        chk("command msb ack", ack, 1'b1);
        M.wbyte(c[7:0], ack);
        chk("command lsb ack", ack, 1'b1);
        M.stop();
    endtask

    // read n bytes, nack on the last
    task automatic read_back(input int n, input logic [15:0] w0, input logic [15:0] w1);
        hdr(8'he1, 1'b1);
        for (int i = 0; i < n; i++) M.rbyte(i == n - 1, b[i]);
        M.stop();
        chk("first word", {b[0], b[1]}, w0);
        if (n > 2) chk("first check byte", b[2], crc8(w0));
        if (n > 4) chk("second word", {b[3], b[4]}, w1);
        if (n > 5) chk("second check byte", b[5], crc8(w1));
    endtask

    task automatic wait_idle();
        for (int k = 0; k < 5000 && idle !== 1'b1; k++) M.tick(1);
        chk("idle", idle, 1'b1);
    endtask

    // watchdog: the whole sequence needs well under 60k cycles
    initial begin
        #9000000;
        fail_count++;
        stop_test();
    end

    initial begin
        repeat (2) @(posedge clk_sys_in);
        #5 rst_n_in = 1'b1;
        hdr(8'he0, 1'b0);
        M.stop();
        wait_idle();
        hdr(8'he2, 1'b0);
        M.stop();
        send_cmd(CMD_READ_ID);
        read_back(3, {FREE, ID_CODE_RESET}, 16'h0000);
        hdr(8'he1, 1'b1);
        M.rbyte(1'b1, b[0]);
        M.rbyte(1'b1, b[1]);
        M.stop();
        chk("line after master nack", b[1], 8'hff);
        for (int k = 0; k < 4; k++) begin
            hum = 16'h1234 + 16'(k);
            tmp = 16'h8765 - 16'(k);
            e0 = (k % 2 == 0) ? tmp : hum;
            e1 = (k % 2 == 0) ? hum : tmp;
            send_cmd(CMDS[k]);
            chk("measuring", meas, 1'b1);
            if (k >= 2) begin
                hdr(8'he1, 1'b0);
                M.stop();
                hdr(8'he0, 1'b0);
                M.stop();
                for (int j = 0; j < 3000 && meas !== 1'b0; j++) M.tick(1);
            end
            read_back(6, e0, e1);
        end
        hum = 16'h0f0f;
        read_back(6, e0, e1);
        read_back(5, e0, e1);
        send_cmd(CMD_SOFT_RESET);
        chk("idle after soft reset", idle, 1'b0);
        wait_idle();
        hdr(8'he1, 1'b0);
        M.stop();
        stop_test();
    end
endmodule
